// ---- common/charger_pkg.sv ----
// Shared constants and types for the charger control block
package charger_pkg;
    // Bus address: group 1001b, device 000b
    localparam logic [6:0] SLAVE_ADDR    = {4'h9, 3'h0};
    // Register subaddresses
    localparam logic [7:0] ADDR_STATUS   = 8'h00;
    localparam logic [7:0] ADDR_TERM     = 8'h02;
    localparam logic [7:0] ADDR_CURR     = 8'h04;
    localparam logic [7:0] ADDR_UNLOCK   = 8'h11;
    localparam logic [7:0] ADDR_PROG     = 8'h12;
    // Field positions
    localparam int         BIT_OV        = 7;
    localparam int         BIT_TSD       = 3;
    localparam int         BIT_UV        = 1;
    localparam int         BIT_UNLOCK    = 0;
    localparam int         BIT_PROG      = 0;
    // Reset values
    localparam logic [7:0] STATUS_RESET  = 8'h00;
    localparam logic [7:0] CFG_RESET     = 8'h00;
    localparam logic       UNLOCK_RESET  = 1'h0;
    localparam logic       PROG_RESET    = 1'h0;
    // Timing
    localparam int         CLK_MHZ       = 100;
    localparam int         SWITCH_KHZ    = 1000;
    localparam logic [6:0] SWITCH_CYCLES = 7'(CLK_MHZ * 1000 / SWITCH_KHZ);
    localparam int         STABLE_MS     = 200;
    localparam int         STABLE_CYCLES = STABLE_MS * CLK_MHZ * 1000;

    typedef enum logic [7:0] {
        ST_IDLE    = 8'h01,
        ST_ADDR    = 8'h02,
        ST_ACKADDR = 8'h04,
        ST_SUB     = 8'h08,
        ST_ACKRX   = 8'h10,
        ST_WRITE   = 8'h20,
        ST_READ    = 8'h40,
        ST_RDACK   = 8'h80
    } serial_state_t;

    typedef enum logic [4:0] {
        CS_OFF      = 5'h01,
        CS_MAXPOWER = 5'h02,
        CS_REGULATE = 5'h04,
        CS_OVFAULT  = 5'h08,
        CS_THERMAL  = 5'h10
    } charge_state_t;

    typedef struct packed {
        logic ovDetect;
        logic tempAboveShutdown;
        logic tempBelowRestart;
        logic vinAboveOn;
        logic vinBelowOff;
        logic termReached;
        logic currentLimit;
    } protect_in_t;

    typedef struct packed {
        logic [7:0] termVoltage;
        logic [7:0] chargeCurrent;
    } nv_cfg_t;
endpackage : charger_pkg

// ---- core/charger_i2c_status_config.sv ----
// Charger serial slave, register bank, fault reporting and charge sequencing
//
// Functional notes
// - Serial slave handles bus clock up to 100 kHz and 400 kHz modes.
// - Slave answers only address 1001b group and 000b device.
// - Matching address byte is acknowledged by holding data low on ninth pulse.
// - Transaction is address byte, subaddress byte, then register data bytes.
// - Falling data while clock high is a Start.
// - Rising data while clock high is a Stop.
// - Bytes move MSB first, one bit per clock pulse.
// - Every received byte of a transaction to the own address is acknowledged by the slave.
// - Master leaves last read byte unacknowledged; slave then releases data line.
// - Any number of bytes between Start and Stop, each with one ack.
// - Register pointer advances after every written byte and every acknowledged read byte.
// - Status 00, configs 02 and 04 from EEPROM, unlock 11, program 12.
// - Configs and program register blocked until unlock register written.
// - Status bit 7 over-voltage fault, bit 3 thermal, bit 1 undervoltage warnings.
// - Fault sets status bit and pulls fault output low.
// - Warning sets status bit but leaves fault output released.
// - Status read clears all bits except those still active; fault output released by the first status read after fault clear.
// - Output over-voltage stops charging and enters fault condition.
// - Thermal shutdown tri-states switch, restarts after cooling, repeats.
// - Stay off until input above on level, disable below off level.
// - Max power until termination, then regulate until fault, disable or drop.
// - Current limit checked every 1 MHz switching cycle, cuts the cycle.
// - Unlock bit 0 read-write, reset 0, grants or withdraws config access.
// - Program bit stores configs to EEPROM once supply present 200 ms.
module charger_i2c_status_config #(
    parameter int STABLE_COUNT = charger_pkg::STABLE_CYCLES
) (
    // Core clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    // Link oversampling clock
    input  wire logic                    linkClk,
    // Serial bus pins
    input  wire logic                    sclIn,
    input  wire logic                    sdaIn,
    output logic                         sdaOut,
    output logic                         sdaOeN,
    // Open-drain fault pin
    output logic                         faultOutLowOut,
    output logic                         faultOutLowOeN,
    // Analog comparators and enable pin
    input  wire logic                    enablePin,
    input  wire charger_pkg::protect_in_t protectIn,
    // Nonvolatile store, linkClk domain
    input  wire charger_pkg::nv_cfg_t    nvDefaults,
    output charger_pkg::nv_cfg_t         cfgOut,
    output logic                         nvProgramStrobe,
    // Power stage
    output logic                         switchNodeHigh,
    output logic                         switchNodeOeN,
    output logic                         maxPowerTracking,
    output logic                         regulateVoltage
);
    typedef struct packed {
        logic                      rstMeta, rstSync;
        logic                      sclMeta, sclSync, sclPrev;
        logic                      sdaMeta, sdaSync, sdaPrev;
        logic                      ovMeta, ovSync, tsdMeta, tsdSync;
        logic                      uvMeta, uvSync, stableMeta, stableSync;
        charger_pkg::serial_state_t st;
        logic [3:0]                bitCnt;
        logic [7:0]                shift, tx, ptr, status;
        logic                      rw, mAck, sdaLow, unlock, prog;
        logic                      loadPending, progStrobe;
        charger_pkg::nv_cfg_t      cfg;
    } link_state_t;

    typedef struct packed {
        logic                      enMeta, enSync, faultMeta, faultSync;
        charger_pkg::protect_in_t  protMeta, protSync;
        charger_pkg::charge_state_t cs;
        logic                      thermalHot, uvLock, pwmOn, stable;
        logic [6:0]                cycleCnt;
        logic [24:0]               stableCnt;
    } core_state_t;

    link_state_t lq, ln;
    core_state_t cq, cn;
    logic        sclRise, sclFall, startSeen, stopSeen, loadTx, coreRun, rxByteDone;
    logic [7:0]  loadAddr, events;

    // Unmapped and locked reads give zero
    function automatic logic [7:0] regRead(input logic [7:0] a, input link_state_t s);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            charger_pkg::ADDR_STATUS: v = s.status;
            charger_pkg::ADDR_TERM:   v = s.unlock ? s.cfg.termVoltage : 8'h00;
            charger_pkg::ADDR_CURR:   v = s.unlock ? s.cfg.chargeCurrent : 8'h00;
            charger_pkg::ADDR_UNLOCK: v[charger_pkg::BIT_UNLOCK] = s.unlock;
            charger_pkg::ADDR_PROG:   v[charger_pkg::BIT_PROG] = s.unlock & s.prog;
            default:                  v = 8'h00;
        endcase
        return v;
    endfunction : regRead

    assign startSeen  = lq.sclSync & lq.sclPrev & lq.sdaPrev & ~lq.sdaSync;
    assign stopSeen   = lq.sclSync & lq.sclPrev & ~lq.sdaPrev & lq.sdaSync;
    assign sclRise    = lq.sclSync & ~lq.sclPrev;
    assign sclFall    = ~lq.sclSync & lq.sclPrev;
    assign rxByteDone = sclFall & (lq.bitCnt == 4'h8);

    always_comb begin
        ln = lq;
        loadTx = 1'b0;
        loadAddr = lq.ptr;
        ln.rstMeta = rst_n;
        ln.rstSync = lq.rstMeta;
        ln.sclMeta = sclIn;
        ln.sclSync = lq.sclMeta;
        ln.sclPrev = lq.sclSync;
        ln.sdaMeta = sdaIn;
        ln.sdaSync = lq.sdaMeta;
        ln.sdaPrev = lq.sdaSync;
        ln.ovMeta = protectIn.ovDetect;
        ln.ovSync = lq.ovMeta;
        ln.tsdMeta = cq.thermalHot;
        ln.tsdSync = lq.tsdMeta;
        ln.uvMeta = cq.uvLock;
        ln.uvSync = lq.uvMeta;
        ln.stableMeta = cq.stable;
        ln.stableSync = lq.stableMeta;
        ln.progStrobe = 1'b0;
        events = 8'h00;
        events[charger_pkg::BIT_OV] = lq.ovSync;
        events[charger_pkg::BIT_TSD] = lq.tsdSync;
        events[charger_pkg::BIT_UV] = lq.uvSync;
        ln.status = lq.status | events;
        if (lq.loadPending) begin
            ln.cfg = nvDefaults;
            ln.loadPending = 1'b0;
        end
        case (lq.st)
            // address, subaddress and data shift in MSB first
            charger_pkg::ST_ADDR, charger_pkg::ST_SUB, charger_pkg::ST_WRITE: begin
                if (sclRise) begin
                    ln.shift = {lq.shift[6:0], lq.sdaSync};
                    ln.bitCnt = lq.bitCnt + 4'h1;
                end else if (rxByteDone) begin
                    ln.st = charger_pkg::ST_ACKRX;
                    ln.sdaLow = 1'b1;
                    if (lq.st == charger_pkg::ST_ADDR) begin
                        ln.rw = lq.shift[0];
                        ln.st = charger_pkg::ST_ACKADDR;
                        if (lq.shift[7:1] != charger_pkg::SLAVE_ADDR) begin
                            ln.st = charger_pkg::ST_IDLE;
                            ln.sdaLow = 1'b0;
                        end
                    end else if (lq.st == charger_pkg::ST_SUB) begin
                        ln.ptr = lq.shift;
                    end else begin
                        ln.ptr = lq.ptr + 8'h01;
                        case (lq.ptr)
                            charger_pkg::ADDR_TERM:
                                if (lq.unlock) ln.cfg.termVoltage = lq.shift;
                            charger_pkg::ADDR_CURR:
                                if (lq.unlock) ln.cfg.chargeCurrent = lq.shift;
                            charger_pkg::ADDR_UNLOCK:
                                ln.unlock = lq.shift[charger_pkg::BIT_UNLOCK];
                            charger_pkg::ADDR_PROG:
                                if (lq.unlock) begin
                                    ln.prog = lq.shift[charger_pkg::BIT_PROG];
                                    ln.progStrobe = lq.shift[charger_pkg::BIT_PROG]
                                                    & lq.stableSync;
                                end
                            default: ln.prog = lq.prog;
                        endcase
                    end
                end
            end
            charger_pkg::ST_ACKADDR: begin
                if (sclFall) begin
                    ln.sdaLow = 1'b0;
                    ln.bitCnt = 4'h0;
                    ln.st = lq.rw ? charger_pkg::ST_READ : charger_pkg::ST_SUB;
                    loadTx = lq.rw;
                end
            end
            // release after ack, take next byte
            charger_pkg::ST_ACKRX: begin
                if (sclFall) begin
                    ln.sdaLow = 1'b0;
                    ln.bitCnt = 4'h0;
                    ln.st = charger_pkg::ST_WRITE;
                end
            end
            charger_pkg::ST_READ: begin
                if (sclRise) begin
                    ln.bitCnt = lq.bitCnt + 4'h1;
                end else if (rxByteDone) begin
                    ln.sdaLow = 1'b0;
                    ln.st = charger_pkg::ST_RDACK;
                end else if (sclFall) begin
                    ln.tx = {lq.tx[6:0], 1'b0};
                    ln.sdaLow = ~lq.tx[6];
                end
            end
            charger_pkg::ST_RDACK: begin
                if (sclRise) begin
                    ln.mAck = ~lq.sdaSync;
                    if (lq.sdaSync) ln.st = charger_pkg::ST_IDLE;
                end else if (sclFall && lq.mAck) begin
                    ln.mAck = 1'b0;
                    ln.bitCnt = 4'h0;
                    ln.ptr = lq.ptr + 8'h01;
                    loadAddr = lq.ptr + 8'h01;
                    loadTx = 1'b1;
                    ln.st = charger_pkg::ST_READ;
                end
            end
            default: ln.st = charger_pkg::ST_IDLE;
        endcase
        if (loadTx) begin
            ln.tx = regRead(loadAddr, lq);
            ln.sdaLow = ~ln.tx[7];
            // read clears, live events set again
            if (loadAddr == charger_pkg::ADDR_STATUS) ln.status = events;
        end
        if (startSeen) begin
            ln.st = charger_pkg::ST_ADDR;
            ln.bitCnt = 4'h0;
            ln.sdaLow = 1'b0;
        end else if (stopSeen) begin
            ln.st = charger_pkg::ST_IDLE;
            ln.sdaLow = 1'b0;
        end
        if (!lq.rstSync) begin
            ln.st = charger_pkg::ST_IDLE;
            ln.bitCnt = 4'h0;
            ln.shift = 8'h00;
            ln.tx = 8'h00;
            ln.ptr = 8'h00;
            ln.status = charger_pkg::STATUS_RESET;
            ln.cfg = {charger_pkg::CFG_RESET, charger_pkg::CFG_RESET};
            ln.unlock = charger_pkg::UNLOCK_RESET;
            ln.prog = charger_pkg::PROG_RESET;
            ln.rw = 1'b0;
            ln.mAck = 1'b0;
            ln.sdaLow = 1'b0;
            ln.loadPending = 1'b1;
            ln.progStrobe = 1'b0;
        end
    end

    always_ff @(posedge linkClk) begin
        lq <= ln;
    end

    assign sdaOut          = 1'b0;
    assign sdaOeN          = ~lq.sdaLow;
    assign faultOutLowOut  = 1'b0;
    // pin follows the fault bit only
    assign faultOutLowOeN  = ~lq.status[charger_pkg::BIT_OV];
    assign cfgOut          = lq.cfg;
    assign nvProgramStrobe = lq.progStrobe;

    // Core domain: protection, sequencing, switching cycle
    assign coreRun = cq.enSync & ~cq.uvLock;

    always_comb begin
        cn = cq;
        cn.enMeta = enablePin;
        cn.enSync = cq.enMeta;
        cn.protMeta = protectIn;
        cn.protSync = cq.protMeta;
        cn.faultMeta = lq.status[charger_pkg::BIT_OV];
        cn.faultSync = cq.faultMeta;
        if (cq.protSync.vinAboveOn) cn.uvLock = 1'b0;
        else if (cq.protSync.vinBelowOff) cn.uvLock = 1'b1;
        if (cq.protSync.tempAboveShutdown) cn.thermalHot = 1'b1;
        else if (cq.protSync.tempBelowRestart) cn.thermalHot = 1'b0;
        // supply present long enough to program
        cn.stableCnt = 25'h0000000;
        if (coreRun) begin
            cn.stableCnt = (cq.stableCnt == 25'(STABLE_COUNT)) ? cq.stableCnt
                           : cq.stableCnt + 25'h0000001;
        end
        cn.stable = coreRun & (cq.stableCnt == 25'(STABLE_COUNT));
        case (cq.cs)
            charger_pkg::CS_OFF:      cn.cs = charger_pkg::CS_MAXPOWER;
            charger_pkg::CS_MAXPOWER:
                if (cq.protSync.termReached) cn.cs = charger_pkg::CS_REGULATE;
            charger_pkg::CS_REGULATE:
                if (!cq.protSync.termReached) cn.cs = charger_pkg::CS_MAXPOWER;
            charger_pkg::CS_OVFAULT, charger_pkg::CS_THERMAL: cn.cs = charger_pkg::CS_OFF;
            default:                  cn.cs = charger_pkg::CS_OFF;
        endcase
        // over-voltage holds the fault until the bit is read away
        if (!coreRun) cn.cs = charger_pkg::CS_OFF;
        else if (cq.protSync.ovDetect || cq.faultSync) cn.cs = charger_pkg::CS_OVFAULT;
        else if (cq.thermalHot) cn.cs = charger_pkg::CS_THERMAL;
        cn.cycleCnt = (cq.cycleCnt == charger_pkg::SWITCH_CYCLES - 7'h01) ? 7'h00
                      : cq.cycleCnt + 7'h01;
        if (cq.cycleCnt == 7'h00) cn.pwmOn = 1'b1;
        if (cq.protSync.currentLimit || cn.cs == charger_pkg::CS_OFF
            || cn.cs == charger_pkg::CS_OVFAULT || cn.cs == charger_pkg::CS_THERMAL) begin
            cn.pwmOn = 1'b0;
        end
        if (!rst_n) begin
            cn.cs = charger_pkg::CS_OFF;
            cn.uvLock = 1'b1;
            cn.thermalHot = 1'b0;
            cn.pwmOn = 1'b0;
            cn.cycleCnt = 7'h00;
            cn.stableCnt = 25'h0000000;
            cn.stable = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        cq <= cn;
    end

    assign switchNodeHigh   = cq.pwmOn;
    assign switchNodeOeN    = ~(cq.cs == charger_pkg::CS_MAXPOWER
                                || cq.cs == charger_pkg::CS_REGULATE);
    assign maxPowerTracking = (cq.cs == charger_pkg::CS_MAXPOWER);
    assign regulateVoltage  = (cq.cs == charger_pkg::CS_REGULATE);

    chk_start_enters_addr: assert property (@(posedge linkClk) disable iff (!lq.rstSync)
        startSeen |=> lq.st == charger_pkg::ST_ADDR && lq.bitCnt == 4'h0 && sdaOeN)
        else $error("start not taken");
    chk_stop_to_idle: assert property (@(posedge linkClk) disable iff (!lq.rstSync)
        stopSeen && !startSeen |=> lq.st == charger_pkg::ST_IDLE && sdaOeN)
        else $error("stop not taken");
    chk_addr_ack_drive: assert property (@(posedge linkClk) disable iff (!lq.rstSync)
        rxByteDone && lq.st == charger_pkg::ST_ADDR && !startSeen && !stopSeen
        && lq.shift[7:1] == charger_pkg::SLAVE_ADDR |=> !sdaOeN && lq.st == charger_pkg::ST_ACKADDR)
        else $error("own address not acknowledged");
    chk_addr_miss_idle: assert property (@(posedge linkClk) disable iff (!lq.rstSync)
        rxByteDone && lq.st == charger_pkg::ST_ADDR && !startSeen && !stopSeen
        && lq.shift[7:1] != charger_pkg::SLAVE_ADDR |=> sdaOeN && lq.st == charger_pkg::ST_IDLE)
        else $error("foreign address answered");
    chk_rx_byte_ack: assert property (@(posedge linkClk) disable iff (!lq.rstSync)
        rxByteDone && lq.st == charger_pkg::ST_WRITE && !startSeen && !stopSeen
        |=> !sdaOeN && lq.ptr == $past(lq.ptr) + 8'h01)
        else $error("write byte not acked or pointer stuck");
    chk_nack_release: assert property (@(posedge linkClk) disable iff (!lq.rstSync)
        sclRise && lq.sdaSync && lq.st == charger_pkg::ST_RDACK && !startSeen && !stopSeen
        |=> sdaOeN && lq.st == charger_pkg::ST_IDLE)
        else $error("data line held after nack");
    chk_locked_write: assert property (@(posedge linkClk) disable iff (!lq.rstSync)
        rxByteDone && lq.st == charger_pkg::ST_WRITE && !lq.unlock && !lq.loadPending
        |=> $stable(lq.cfg))
        else $error("config changed while locked");
    chk_status_read_clr: assert property (@(posedge linkClk) disable iff (!lq.rstSync)
        loadTx && loadAddr == charger_pkg::ADDR_STATUS && events == 8'h00
        |=> lq.status == 8'h00 ##1 faultOutLowOeN)
        else $error("status not cleared by read");
    chk_fault_pin_low: assert property (@(posedge linkClk) disable iff (!lq.rstSync)
        lq.ovSync |=> !faultOutLowOeN)
        else $error("fault pin not pulled low");
    chk_ov_stops_charge: assert property (@(posedge clk) disable iff (!rst_n)
        cq.protSync.ovDetect && coreRun |=> cq.cs == charger_pkg::CS_OVFAULT ##0 switchNodeOeN)
        else $error("charging not stopped on over-voltage");
    chk_limit_cuts_cycle: assert property (@(posedge clk) disable iff (!rst_n)
        cq.protSync.currentLimit |=> !switchNodeHigh)
        else $error("cycle not cut at current limit");
    chk_uvlo_holds_off: assert property (@(posedge clk) disable iff (!rst_n)
        cq.uvLock && !cq.protSync.vinAboveOn |=> cq.uvLock ##1 !$rose(maxPowerTracking))
        else $error("started below on threshold");
endmodule : charger_i2c_status_config

// ---- bench/i2c_host_model.sv ----
// Behavioural serial bus master for the charger bench
module i2c_host_model #(
    // quarter bit of 650 ns keeps the rate under 400 kHz
    parameter int QUARTER = 650
) (
    // Wired data line level
    input  wire logic sdaBus,
    // Line drives, high means released
    output logic      sclLine,
    output logic      sdaDrive
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sclLine  = 1'b1;
        sdaDrive = 1'b1;
    end
    // data moves only while clock low
    task automatic bitXfer(input logic b, output logic seen);
        sdaDrive = b;
        #QUARTER sclLine = 1'b1;
        #QUARTER seen = sdaBus;
        #QUARTER sclLine = 1'b0;
        #QUARTER;
    endtask : bitXfer
    // data falls while clock high, also repeated
    task automatic startCond();
        sdaDrive = 1'b1;
        #QUARTER sclLine = 1'b1;
        #QUARTER sdaDrive = 1'b0;
        #QUARTER sclLine = 1'b0;
        #QUARTER;
    endtask : startCond
    task automatic stopCond();
        sdaDrive = 1'b0;
        #QUARTER sclLine = 1'b1;
        #QUARTER sdaDrive = 1'b1;
        #(2 * QUARTER);
    endtask : stopCond
    // MSB first, then one ack bit from the receiver
    task automatic byteXfer(input logic [7:0] tx, input logic ackIn,
                            output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) bitXfer(tx[i], rx[i]);
        bitXfer(ackIn, ack);
    endtask : byteXfer
endmodule : i2c_host_model

// ---- bench/charger_i2c_status_config_tb.sv ----
// Self-checking bench for the charger control block
`define CHECK(what, exp, got) begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
        badCount++; \
        $display("BAD %s expected %h seen %h", what, exp, got); \
    end \
end
module charger_i2c_status_config_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam charger_pkg::nv_cfg_t NV = '{termVoltage: 8'h5A, chargeCurrent: 8'hC3};
    logic clk = 1'b0, linkClk = 1'b0, rst_n = 1'b0, enablePin = 1'b1, progSeen = 1'b0;
    charger_pkg::protect_in_t protectIn = '{vinAboveOn: 1'b1, default: 1'b0};
    charger_pkg::nv_cfg_t cfgOut;
    logic sdaOut, sdaOeN, faultOutLowOut, faultOutLowOeN, nvProgramStrobe, ack;
    logic switchNodeHigh, switchNodeOeN, maxPowerTracking, regulateVoltage, sclLine, sdaDrive;
    logic [7:0] rd [5];
    int badCount = 0;
    int comparisons = 0;
    // Pull-up wins unless someone pulls low
    wire sdaBus = sdaDrive & (sdaOeN | sdaOut);
    always #5 clk = ~clk;
    // Odd offset keeps the link edges away from the core edges
    initial begin
        #3.3;
        forever #16 linkClk = ~linkClk;
    end
    always @(posedge linkClk) if (nvProgramStrobe === 1'b1) progSeen <= 1'b1;
    i2c_host_model u_host (.sdaBus(sdaBus), .sclLine(sclLine), .sdaDrive(sdaDrive));
    charger_i2c_status_config #(.STABLE_COUNT(20)) u_dut (
        .clk(clk), .rst_n(rst_n), .linkClk(linkClk), .sclIn(sclLine), .sdaIn(sdaBus),
        .sdaOut(sdaOut), .sdaOeN(sdaOeN), .faultOutLowOut(faultOutLowOut),
        .faultOutLowOeN(faultOutLowOeN), .enablePin(enablePin), .protectIn(protectIn),
        .nvDefaults(NV), .cfgOut(cfgOut), .nvProgramStrobe(nvProgramStrobe),
        .switchNodeHigh(switchNodeHigh), .switchNodeOeN(switchNodeOeN),
        .maxPowerTracking(maxPowerTracking), .regulateVoltage(regulateVoltage));
    task automatic sendByte(input logic [7:0] b);
        logic [7:0] unused;
        u_host.byteXfer(b, 1'b1, unused, ack);
        `CHECK("ack", 1'b0, ack)
    endtask : sendByte
    task automatic regWrite(input logic [7:0] sub, input logic [7:0] d [3], input int n);
        u_host.startCond();
        sendByte({charger_pkg::SLAVE_ADDR, 1'b0});
        sendByte(sub);
        for (int i = 0; i < n; i++) sendByte(d[i]);
        u_host.stopCond();
    endtask : regWrite
    task automatic readCheck(input logic [7:0] sub, input logic [7:0] e [5], input int n,
                             input int first);
        u_host.startCond();
        sendByte({charger_pkg::SLAVE_ADDR, 1'b0});
        sendByte(sub);
        u_host.startCond();
        sendByte({charger_pkg::SLAVE_ADDR, 1'b1});
        for (int i = 0; i < n; i++) u_host.byteXfer(8'hFF, i == n - 1, rd[i], ack);
        `CHECK("release", 1'b1, sdaBus)
        u_host.stopCond();
        for (int i = first; i < n; i++) `CHECK("rdata", e[i], rd[i])
    endtask : readCheck
    task automatic completeRun();
        if (badCount == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : completeRun
    initial begin
        #1_600_000;
        badCount++;
        completeRun();
    end
    initial begin
        repeat (5) @(posedge linkClk);
        #1 rst_n = 1'b1;
        repeat (40) @(posedge clk);
        `CHECK("cfg", NV, cfgOut)
        `CHECK("maxpower", 1'b1, maxPowerTracking)
        @(posedge clk) #1 protectIn.currentLimit = 1'b1;
        protectIn.termReached = 1'b1;
        repeat (6) @(posedge clk);
        #1 `CHECK("limit", 1'b0, switchNodeHigh)
        `CHECK("regulate", 1'b1, regulateVoltage)
        protectIn.currentLimit = 1'b0;
        protectIn.termReached = 1'b0;
        readCheck(8'h00, '{default: 8'h00}, 5, 1);
        u_host.startCond();
        u_host.byteXfer({7'h4C, 1'b0}, 1'b1, rd[0], ack);
        `CHECK("foreign", 1'b1, ack)
        u_host.stopCond();
        regWrite(charger_pkg::ADDR_TERM, '{8'h11, 8'h00, 8'h00}, 1);
        `CHECK("locked", NV, cfgOut)
        regWrite(charger_pkg::ADDR_UNLOCK, '{8'h01, 8'h00, 8'h00}, 1);
        regWrite(charger_pkg::ADDR_TERM, '{8'hA5, 8'h77, 8'h3C}, 3);
        `CHECK("cfg", 16'hA53C, cfgOut)
        readCheck(charger_pkg::ADDR_TERM, '{8'hA5, 8'h00, 8'h3C, 8'h00, 8'h00}, 3, 0);
        regWrite(charger_pkg::ADDR_PROG, '{8'h01, 8'h00, 8'h00}, 1);
        repeat (4) @(posedge linkClk);
        `CHECK("program", 1'b1, progSeen)
        readCheck(charger_pkg::ADDR_UNLOCK, '{8'h01, 8'h01, 8'h00, 8'h00, 8'h00}, 2, 0);
        @(posedge clk) #1 protectIn.ovDetect = 1'b1;
        repeat (10) @(posedge linkClk);
        `CHECK("faultpin", 1'b0, faultOutLowOeN)
        `CHECK("maxpower", 1'b0, maxPowerTracking)
        readCheck(charger_pkg::ADDR_STATUS, '{0: 8'h80, default: 8'h00}, 1, 0);
        readCheck(charger_pkg::ADDR_STATUS, '{0: 8'h80, default: 8'h00}, 1, 0);
        @(posedge clk) #1 protectIn.ovDetect = 1'b0;
        protectIn.tempAboveShutdown = 1'b1;
        repeat (10) @(posedge linkClk);
        `CHECK("faultpin", 1'b0, faultOutLowOeN)
        `CHECK("switchoff", 1'b1, switchNodeOeN)
        readCheck(charger_pkg::ADDR_STATUS, '{0: 8'h88, default: 8'h00}, 1, 0);
        repeat (4) @(posedge linkClk);
        `CHECK("faultpin", 1'b1, faultOutLowOeN)
        @(posedge clk) #1 protectIn.tempAboveShutdown = 1'b0;
        protectIn.tempBelowRestart = 1'b1;
        repeat (4) @(posedge linkClk);
        `CHECK("restart", 1'b1, maxPowerTracking)
        @(posedge clk) #1 protectIn.vinAboveOn = 1'b0;
        protectIn.vinBelowOff = 1'b1;
        repeat (10) @(posedge linkClk);
        `CHECK("uvlo", 1'b0, maxPowerTracking)
        `CHECK("warnpin", 1'b1, faultOutLowOeN)
        completeRun();
    end
endmodule : charger_i2c_status_config_tb
